/* logic/port_mux_pkg.sv */
/*
  Constants and types for the port pin mode and alternate-function mux.
  Assumes the mux is reached over the 8-bit special function register strobes of the core.
*/
package port_mux_pkg;

  // ===========================================================
  // pin modes
  typedef enum logic [1:0] {
    MODE_OD_PULL   = 2'b00,
    MODE_OD_HIZ    = 2'b01,
    MODE_PUSH_PULL = 2'b10,
    MODE_ANALOG    = 2'b11
  } pin_mode_t;

  // ===========================================================
  // register map
  localparam int NUM_PINS = 17;
  localparam int NUM_REGS = 12;
  localparam int REG_P1_HIGH = 0;
  localparam int REG_P3_LOW  = 1;
  localparam int REG_P3_HIGH = 2;
  localparam int REG_ROUTE   = 3;
  localparam int REG_CMP1    = 4;
  localparam int REG_TWM     = 9;
  localparam int REG_AMP     = 10;
  localparam int REG_AMP_CAL = 11;
  localparam logic [7:0] REG_ADDR [NUM_REGS] = '{8'ha3, 8'ha4, 8'ha5, 8'ha6, 8'hc1, 8'hc2,
                                                 8'hc3, 8'hc4, 8'hc5, 8'he1, 8'hee, 8'hef};
  localparam logic [7:0] REG_RESET [NUM_REGS] = '{8'h55, 8'h55, 8'h55, 8'h01, 8'h00, 8'h00,
                                                  8'h00, 8'h00, 8'h00, 8'h04, 8'h00, 8'h00};
  // writable bits; reserved and read-only bits stay zero in storage
  localparam logic [7:0] REG_WMASK [NUM_REGS] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'hdf, 8'hff,
                                                  8'hff, 8'hff, 8'hff, 8'hef, 8'hbf, 8'hff};

  // ===========================================================
  // field positions
  localparam int ROUTE_PWM_B     = 7;
  localparam int ROUTE_PWM_A_POS = 6;
  localparam int ROUTE_PWM_A_NEG = 5;
  localparam int ROUTE_TIMER_C   = 4;
  localparam int ROUTE_TIMER_B   = 3;
  localparam int ROUTE_TIMER_A   = 2;
  localparam int P22_MODE_LSB    = 0;
  localparam int CTRL_EN_BIT     = 7;
  localparam int TWM_FLAG_BIT    = 5;
  localparam int TWM_ACK_BIT     = 4;
  localparam int AMP_OUT_BIT     = 5;
  localparam int AMP_FUNC_LSB    = 3;
  localparam int AMP_CAL_BIT     = 6;

  // ===========================================================
  // pin indexes: 0..7 port1, 8 port2 pin2, 9..16 port3
  localparam int PIN_P1_0 = 0;
  localparam int PIN_P1_1 = 1;
  localparam int PIN_P1_2 = 2;
  localparam int PIN_P1_3 = 3;
  localparam int PIN_P1_4 = 4;
  localparam int PIN_P1_5 = 5;
  localparam int PIN_P1_6 = 6;
  localparam int PIN_P1_7 = 7;
  localparam int PIN_P3_0 = 9;
  localparam int PIN_P3_1 = 10;
  localparam int PIN_P3_2 = 11;
  localparam int PIN_P3_3 = 12;
  localparam int PIN_P3_4 = 13;
  localparam int PIN_P3_5 = 14;
  localparam logic [16:0] ADC_PIN_MASK    = 17'h1ff45;
  localparam logic [16:0] PSEUDO_PIN_MASK = 17'h00fff;

  // ===========================================================
  // timer clock outputs: index 0 timer a, 1 timer b, 2 timer c
  localparam int TIMER_A_DIV = 64;
  localparam int TIMER_B_DIV = 2;
  localparam int TIMER_C_DIV = 2;
  localparam logic [4:0] TOGGLE_LAST [3] = '{5'(TIMER_A_DIV / 2 - 1), 5'(TIMER_B_DIV / 2 - 1),
                                             5'(TIMER_C_DIV / 2 - 1)};

endpackage

/* logic/port_pin_function_mux.sv */
/*
  Pin mode and alternate-function routing for port1, port2 pin2 and port3.
  Assumes registered pads, port data latches and the low port1 mode register held elsewhere.
*/
`timescale 1ns/1ps
`default_nettype none

module port_pin_function_mux (
  // clock and reset
  input  wire logic        mclk_i,
  input  wire logic        rst_n_i,
  // register strobes
  input  wire logic [7:0]  sfr_addr_i,
  input  wire logic        sfr_wr_i,
  input  wire logic        sfr_rd_i,
  input  wire logic [7:0]  sfr_wdata_i,
  output logic      [7:0]  sfr_rdata_o,
  output logic             sfr_hit_o,
  // port data latches and low port1 modes
  input  wire logic [16:0] port_data_i,
  input  wire logic [7:0]  port1_low_pin_modes_i,
  // peripheral sources
  input  wire logic        pwm_b_output_i,
  input  wire logic        pwm_a_pos_output_i,
  input  wire logic        pwm_a_neg_output_i,
  input  wire logic [2:0]  timer_ovf_i,
  input  wire logic        twm_data_out_i,
  input  wire logic        twm_clock_out_i,
  input  wire logic        twm_ack_i,
  input  wire logic        twm_done_i,
  // pads
  input  wire logic [16:0] pad_in_i,
  output logic      [16:0] pad_out_o,
  output logic      [16:0] pad_oe_n_o,
  output logic      [16:0] pad_pullup_o,
  // to core and peripherals
  output logic      [16:0] pin_in_o,
  output logic      [16:0] adc_pin_en_o,
  output logic      [16:0] analog_claim_o,
  output logic      [4:0]  comparator_en_o,
  output logic             two_wire_master_en_o,
  output logic             amplifier_en_o,
  output logic             amplifier_out_pin_o,
  output logic      [2:0]  timer_clkout_o,
  output logic      [4:0][7:0] comparator_ctrl_o,
  output logic      [7:0]  two_wire_ctrl_o,
  output logic      [7:0]  amplifier_ctrl_o,
  output logic      [7:0]  amplifier_cal_o
);

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  // ===========================================================
  // register file
  logic [7:0]  regs [port_mux_pkg::NUM_REGS];
  logic [11:0] wr_hit;
  logic [7:0]  rd_value;
  logic        rd_any;

  for (genvar i = 0; i < port_mux_pkg::NUM_REGS; i++) begin : g_reg
    wire       hit = (sfr_addr_i == port_mux_pkg::REG_ADDR[i]);
    wire [7:0] wm  = port_mux_pkg::REG_WMASK[i];
    wire [7:0] hw_set;
    wire [7:0] next_reg;
    assign wr_hit[i] = hit & sfr_wr_i;
    // controller completion flag is set by hardware and wins over a write
    assign hw_set   = (i == port_mux_pkg::REG_TWM) ? 8'(twm_done_i) << port_mux_pkg::TWM_FLAG_BIT : 8'h00;
    assign next_reg = (wr_hit[i] ? ((sfr_wdata_i & wm) | (regs[i] & ~wm)) : regs[i]) | hw_set;
    always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
        regs[i] <= port_mux_pkg::REG_RESET[i];
      end else begin
        regs[i] <= next_reg;
      end
    end
  end

  always_comb begin
    rd_value = 8'h00;
    rd_any   = 1'b0;
    for (int i = 0; i < port_mux_pkg::NUM_REGS; i++) begin
      if (sfr_addr_i == port_mux_pkg::REG_ADDR[i]) begin
        rd_any   = 1'b1;
        rd_value = regs[i];
      end
    end
    if (sfr_addr_i == port_mux_pkg::REG_ADDR[port_mux_pkg::REG_TWM]) begin
      rd_value[port_mux_pkg::TWM_ACK_BIT] = twm_ack_i;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      sfr_rdata_o <= 8'h00;
      sfr_hit_o   <= 1'b0;
    end else begin
      sfr_rdata_o <= sfr_rd_i ? rd_value : 8'h00;
      sfr_hit_o   <= sfr_rd_i & rd_any;
    end
  end

  a_sfr_readback: assert property (
    (sfr_wr_i && sfr_addr_i == 8'ha3) ##1 (sfr_rd_i && sfr_addr_i == 8'ha3 && !sfr_wr_i)
      |=> sfr_hit_o && sfr_rdata_o == $past(sfr_wdata_i, 2))
    else $error("mode register read does not return written value");

  // ===========================================================
  // named register fields
  wire [7:0] route    = regs[port_mux_pkg::REG_ROUTE];
  wire [7:0] amp_ctrl = regs[port_mux_pkg::REG_AMP];
  wire [7:0] amp_cal  = regs[port_mux_pkg::REG_AMP_CAL];
  wire [1:0] amp_func = amp_ctrl[port_mux_pkg::AMP_FUNC_LSB +: 2];
  wire       amp_cal_mode = amp_cal[port_mux_pkg::AMP_CAL_BIT];

  for (genvar c = 0; c < 5; c++) begin : g_cmp
    assign comparator_ctrl_o[c] = regs[port_mux_pkg::REG_CMP1 + c];
    assign comparator_en_o[c]   = regs[port_mux_pkg::REG_CMP1 + c][port_mux_pkg::CTRL_EN_BIT];
  end
  assign two_wire_ctrl_o      = regs[port_mux_pkg::REG_TWM];
  assign amplifier_ctrl_o     = amp_ctrl;
  assign amplifier_cal_o      = amp_cal;
  assign two_wire_master_en_o = two_wire_ctrl_o[port_mux_pkg::CTRL_EN_BIT];
  assign amplifier_en_o       = amp_ctrl[port_mux_pkg::CTRL_EN_BIT];
  assign amplifier_out_pin_o  = amplifier_en_o & amp_ctrl[port_mux_pkg::AMP_OUT_BIT];

  // ===========================================================
  // mode fields, lowest pin in the lowest pair of each register
  wire [33:0] mode_vec = {regs[port_mux_pkg::REG_P3_HIGH], regs[port_mux_pkg::REG_P3_LOW],
                          route[port_mux_pkg::P22_MODE_LSB +: 2], regs[port_mux_pkg::REG_P1_HIGH],
                          port1_low_pin_modes_i};

  // ===========================================================
  // amplifier pin claims
  wire amp_func_both = (amp_func == 2'b11);
  wire amp_claim_p0  = amplifier_en_o & (amp_cal_mode ? amp_func_both
                                                      : (amp_func == 2'b00) | amp_func_both);
  wire amp_claim_p1  = amplifier_en_o & (amp_cal_mode ? amp_func_both : (amp_func != 2'b00));

  a_amp_cal_claim: assert property (
    (amplifier_en_o && amp_cal_mode && amp_func != 2'b11)
      |-> !analog_claim_o[port_mux_pkg::PIN_P1_0] && !analog_claim_o[port_mux_pkg::PIN_P1_1])
    else $error("calibration mode claimed an amplifier input pin");
  a_amp_normal_claim: assert property (
    (amplifier_en_o && !amp_cal_mode && amp_func == 2'b01)
      |-> analog_claim_o[port_mux_pkg::PIN_P1_1] && !analog_claim_o[port_mux_pkg::PIN_P1_0])
    else $error("normal mode function 01 claims wrong pins");
  a_amp_out_gate: assert property (!amplifier_en_o |-> !amplifier_out_pin_o)
    else $error("amplifier output on pin while amplifier disabled");

  // ===========================================================
  // analog claims by comparators and amplifier
  always_comb begin
    analog_claim_o = '0;
    analog_claim_o[port_mux_pkg::PIN_P1_3] = comparator_en_o[0];
    analog_claim_o[port_mux_pkg::PIN_P1_4] = comparator_en_o[0];
    analog_claim_o[port_mux_pkg::PIN_P1_5] = comparator_en_o[1];
    analog_claim_o[port_mux_pkg::PIN_P1_7] = comparator_en_o[2];
    analog_claim_o[port_mux_pkg::PIN_P1_6] = comparator_en_o[3] | amplifier_out_pin_o;
    analog_claim_o[port_mux_pkg::PIN_P3_2] = comparator_en_o[4];
    analog_claim_o[port_mux_pkg::PIN_P1_0] = amp_claim_p0;
    analog_claim_o[port_mux_pkg::PIN_P1_1] = amp_claim_p1;
  end

  // ===========================================================
  // timer clock outputs: toggle after a fixed number of overflows, 32 for timer a and 1 for timers b and c
  logic [4:0] ovf_cnt [3];
  wire  [2:0] clkout_en = {route[port_mux_pkg::ROUTE_TIMER_C], route[port_mux_pkg::ROUTE_TIMER_B],
                           route[port_mux_pkg::ROUTE_TIMER_A]};

  for (genvar t = 0; t < 3; t++) begin : g_tmr
    wire last = (ovf_cnt[t] == port_mux_pkg::TOGGLE_LAST[t]);
    always_ff @(posedge mclk_i) begin
      if (!rst_n_i || !clkout_en[t]) begin
        ovf_cnt[t]        <= 5'h00;
        timer_clkout_o[t] <= 1'b0;
      end else if (timer_ovf_i[t]) begin
        ovf_cnt[t]        <= last ? 5'h00 : ovf_cnt[t] + 5'h01;
        timer_clkout_o[t] <= timer_clkout_o[t] ^ last;
      end
    end
  end

  a_tmr_a_div64: assert property (
    (clkout_en[0] && timer_ovf_i[0] && ovf_cnt[0] == 5'h1f) |=> timer_clkout_o[0] != $past(timer_clkout_o[0]))
    else $error("timer a clock output missed toggle after 32 overflows");
  a_tmr_a_hold: assert property (
    (clkout_en[0] && timer_ovf_i[0] && ovf_cnt[0] != 5'h1f) |=> $stable(timer_clkout_o[0]))
    else $error("timer a clock output toggled early");
  a_tmr_c_div2: assert property (
    (clkout_en[2] && timer_ovf_i[2]) |=> timer_clkout_o[2] != $past(timer_clkout_o[2]))
    else $error("timer c clock output did not toggle on overflow");
  a_tmr_b_div2: assert property (
    (clkout_en[1] && timer_ovf_i[1]) |=> timer_clkout_o[1] != $past(timer_clkout_o[1]))
    else $error("timer b clock output did not toggle on overflow");

  // ===========================================================
  // peripheral output routing
  logic [16:0] alt_en;
  logic [16:0] alt_val;
  wire pwm_a_pos_sel = route[port_mux_pkg::ROUTE_PWM_A_POS];

  always_comb begin
    alt_en  = '0;
    alt_val = '0;
    alt_en[port_mux_pkg::PIN_P3_3]  = route[port_mux_pkg::ROUTE_PWM_B];
    alt_val[port_mux_pkg::PIN_P3_3] = pwm_b_output_i;
    alt_en[port_mux_pkg::PIN_P3_5]  = pwm_a_pos_sel | clkout_en[1];
    alt_val[port_mux_pkg::PIN_P3_5] = pwm_a_pos_sel ? pwm_a_pos_output_i : timer_clkout_o[1];
    alt_en[port_mux_pkg::PIN_P1_2]  = route[port_mux_pkg::ROUTE_PWM_A_NEG];
    alt_val[port_mux_pkg::PIN_P1_2] = pwm_a_neg_output_i;
    alt_en[port_mux_pkg::PIN_P1_0]  = clkout_en[2];
    alt_val[port_mux_pkg::PIN_P1_0] = timer_clkout_o[2];
    alt_en[port_mux_pkg::PIN_P3_4]  = clkout_en[0];
    alt_val[port_mux_pkg::PIN_P3_4] = timer_clkout_o[0];
    alt_en[port_mux_pkg::PIN_P3_0]  = two_wire_master_en_o;
    alt_val[port_mux_pkg::PIN_P3_0] = twm_data_out_i;
    alt_en[port_mux_pkg::PIN_P3_1]  = two_wire_master_en_o;
    alt_val[port_mux_pkg::PIN_P3_1] = twm_clock_out_i;
  end

  // ===========================================================
  // per-pin driver control
  logic [16:0] src_q;

  for (genvar k = 0; k < port_mux_pkg::NUM_PINS; k++) begin : g_pin
    wire [1:0] field = mode_vec[2 * k +: 2];
    port_mux_pkg::pin_mode_t mode;
    assign mode = port_mux_pkg::pin_mode_t'(field);
    wire analog   = (mode == port_mux_pkg::MODE_ANALOG) | analog_claim_o[k];
    wire src      = alt_en[k] ? alt_val[k] : port_data_i[k];
    wire od_mode  = (mode == port_mux_pkg::MODE_OD_PULL) | (mode == port_mux_pkg::MODE_OD_HIZ);
    // pseudo open drain pins push high for one cycle on a rising edge
    wire boost    = port_mux_pkg::PSEUDO_PIN_MASK[k] & od_mode & src & ~src_q[k];
    wire next_drv = ~analog & ((mode == port_mux_pkg::MODE_PUSH_PULL) | ~src | boost);
    wire next_pu  = ~analog & (mode == port_mux_pkg::MODE_OD_PULL) & src;
    wire next_din = ~analog & od_mode;
    assign adc_pin_en_o[k] = port_mux_pkg::ADC_PIN_MASK[k] & (mode == port_mux_pkg::MODE_ANALOG);
    always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
        src_q[k]        <= 1'b1;
        pad_out_o[k]    <= 1'b1;
        pad_oe_n_o[k]   <= 1'b1;
        pad_pullup_o[k] <= 1'b0;
        pin_in_o[k]     <= 1'b0;
      end else begin
        src_q[k]        <= src;
        pad_out_o[k]    <= src;
        pad_oe_n_o[k]   <= ~next_drv;
        pad_pullup_o[k] <= next_pu;
        pin_in_o[k]     <= next_din & pad_in_i[k];
      end
    end
  end

  a_adc_p1_6: assert property (
    adc_pin_en_o[port_mux_pkg::PIN_P1_6] == (regs[port_mux_pkg::REG_P1_HIGH][5:4] == 2'b11))
    else $error("port1 pin6 ADC select does not follow its mode field");
  a_adc_port3: assert property (
    adc_pin_en_o[16] == (regs[port_mux_pkg::REG_P3_HIGH][7:6] == 2'b11)
    && adc_pin_en_o[9] == (regs[port_mux_pkg::REG_P3_LOW][1:0] == 2'b11))
    else $error("port3 ADC select does not follow its mode field");
  a_adc_p2_2: assert property (adc_pin_en_o[8] == (route[1:0] == 2'b11))
    else $error("port2 pin2 ADC select does not follow its mode field");
  a_pwm_b_route: assert property (
    (route[7] && mode_vec[25:24] == 2'b10 && !analog_claim_o[12])
      |=> !pad_oe_n_o[12] && pad_out_o[12] == $past(pwm_b_output_i))
    else $error("pwm b not driven on port3 pin3");
  a_pwm_a_pos_route: assert property (
    (route[6] && mode_vec[29:28] == 2'b10) |=> pad_out_o[14] == $past(pwm_a_pos_output_i))
    else $error("pwm a positive output not on port3 pin5");
  a_pwm_a_neg_route: assert property (
    (route[5] && mode_vec[5:4] != 2'b11 && !analog_claim_o[2]) |=> pad_out_o[2] == $past(pwm_a_neg_output_i))
    else $error("pwm a negative output not on port1 pin2");
  a_cmp1_claim: assert property (
    comparator_en_o[0] |=> pad_oe_n_o[3] && pad_oe_n_o[4] && !pin_in_o[3] && !pad_pullup_o[4])
    else $error("comparator one inputs still driven");
  a_cmp5_claim: assert property (comparator_en_o[4] |=> pad_oe_n_o[11] && !pin_in_o[11])
    else $error("comparator five input still driven");
  a_twm_pins: assert property (
    (two_wire_master_en_o && mode_vec[19:18] != 2'b11 && !twm_data_out_i) |=> !pad_oe_n_o[9])
    else $error("two-wire data low not driven on port3 pin0");
  a_mode1_hiz: assert property (
    (mode_vec[31:30] == 2'b01 && !alt_en[15] && port_data_i[15] && src_q[15])
      |=> pad_oe_n_o[15] && !pad_pullup_o[15])
    else $error("mode 1 pin with data 1 is not high impedance");
  a_mode0_pull: assert property (
    (mode_vec[31:30] == 2'b00 && port_data_i[15] && src_q[15]) |=> pad_oe_n_o[15] && pad_pullup_o[15])
    else $error("mode 0 pin with data 1 lacks pull-up");
  a_pseudo_boost: assert property (
    (mode_vec[1:0] == 2'b01 && !analog_claim_o[0] && !alt_en[0] && port_data_i[0] && !src_q[0])
      |=> !pad_oe_n_o[0] && pad_out_o[0])
    else $error("pseudo open drain pin missed rising edge drive");

  // ===========================================================
  // pad states, claims and pad sources
  a_cmp2_claim: assert property (
    comparator_en_o[1] |=> pad_oe_n_o[5] && !pin_in_o[5] && !pad_pullup_o[5])
    else $error("comparator two input still driven");
  a_cmp3_claim: assert property (
    comparator_en_o[2] |=> pad_oe_n_o[7] && !pin_in_o[7] && !pad_pullup_o[7])
    else $error("comparator three input still driven");
  a_cmp4_claim: assert property (
    comparator_en_o[3] |=> pad_oe_n_o[6] && !pin_in_o[6] && !pad_pullup_o[6])
    else $error("comparator four input still driven");
  a_amp_out_pad: assert property (
    amplifier_out_pin_o |=> pad_oe_n_o[6] && !pin_in_o[6] && !pad_pullup_o[6])
    else $error("amplifier output pin still driven digitally");
  a_amp_both_claim: assert property (
    (amplifier_en_o && amp_func_both) |-> analog_claim_o[0] && analog_claim_o[1])
    else $error("function 11 does not claim both amplifier inputs");
  a_mode2_drive: assert property (
    (mode_vec[31:30] == 2'b10) |=> !pad_oe_n_o[15] && !pad_pullup_o[15] && !pin_in_o[15])
    else $error("mode 2 pin is not push-pull");
  a_analog_pad: assert property (
    (mode_vec[31:30] == 2'b11) |=> pad_oe_n_o[15] && !pad_pullup_o[15] && !pin_in_o[15])
    else $error("mode 3 pin not released to analog");
  a_pwm_b_off: assert property (
    !route[7] |=> pad_out_o[12] == $past(port_data_i[12]))
    else $error("port3 pin3 source is not port data with pwm b off");
  a_pwm_a_neg_off: assert property (
    !route[5] |=> pad_out_o[2] == $past(port_data_i[2]))
    else $error("port1 pin2 source is not port data with pwm a negative off");
  a_tmr_b_pin: assert property (
    (!route[6] && clkout_en[1]) |=> pad_out_o[14] == $past(timer_clkout_o[1]))
    else $error("timer b clock output not on port3 pin5");
  a_tmr_a_pin: assert property (
    clkout_en[0] |=> pad_out_o[13] == $past(timer_clkout_o[0]))
    else $error("timer a clock output not on port3 pin4");
  a_tmr_c_pin: assert property (
    clkout_en[2] |=> pad_out_o[0] == $past(timer_clkout_o[2]))
    else $error("timer c clock output not on port1 pin0");
  a_tmr_off: assert property (
    (!clkout_en[1] && !clkout_en[2]) |=> timer_clkout_o[2:1] == 2'b00)
    else $error("disabled timer clock output not cleared");
  a_twm_clock_pin: assert property (
    (two_wire_master_en_o && mode_vec[21:20] != 2'b11 && !twm_clock_out_i) |=> !pad_oe_n_o[10])
    else $error("two-wire clock low not driven on port3 pin1");

  c_pwm_b_out: cover property (route[7] ##1 !pad_oe_n_o[12] && pad_out_o[12]);
  c_cmp_claim: cover property (comparator_en_o[0] ##1 pad_oe_n_o[3]);
  c_tmr_a_toggle: cover property (clkout_en[0] && timer_ovf_i[0] && ovf_cnt[0] == 5'h1f);
  c_amp_both: cover property (amplifier_en_o && amp_cal_mode && amp_func_both);
  c_twm_flag: cover property (twm_done_i && wr_hit[port_mux_pkg::REG_TWM]);

endmodule

`default_nettype wire

/* tb/pad_world.sv */
/*
  Outside world of the port pads: resolves every pad level from the mux outputs.
  Assumes the bench supplies the level that an undriven, unpulled pad floats to.
*/
`timescale 1ns/1ps
`default_nettype none

module pad_world (
  // pad side of the mux
  input  wire logic [16:0] pad_out_i,
  input  wire logic [16:0] pad_oe_n_i,
  input  wire logic [16:0] pad_pullup_i,
  // level seen when nothing drives and no pull-up
  input  wire logic [16:0] ext_i,
  output logic      [16:0] pad_in_o
);
  // ===========================================================
  // wire resolution
  assign pad_in_o = (~pad_oe_n_i & pad_out_i) | (pad_oe_n_i & (pad_pullup_i | ext_i));
endmodule

`default_nettype wire

/* tb/tb_top.sv */
/*
  Self-checking bench for the port pin function mux.
  Assumes pad_world closes the pads and registers are reached over the sfr strobes.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  // ===========================================================
  // wiring
  logic mclk_i = 1'b0, rst_n_i = 1'b0, sfr_wr_i = 1'b0, sfr_rd_i = 1'b0, took = 1'b0;
  logic [7:0] sfr_addr_i = 8'h00, sfr_wdata_i = 8'h00, port1_low_pin_modes_i = 8'h55;
  logic [16:0] port_data_i = 17'h1ffff, ext_level = 17'h0, pad_in_i;
  logic pwm_b_output_i = 1'b0, pwm_a_pos_output_i = 1'b0, pwm_a_neg_output_i = 1'b0;
  logic twm_data_out_i = 1'b1, twm_clock_out_i = 1'b1, twm_ack_i = 1'b0, twm_done_i = 1'b0;
  logic [2:0] timer_ovf_i = 3'h0, timer_clkout_o;
  logic [7:0] sfr_rdata_o, two_wire_ctrl_o, amplifier_ctrl_o, amplifier_cal_o;
  logic sfr_hit_o, two_wire_master_en_o, amplifier_en_o, amplifier_out_pin_o;
  logic [16:0] pad_out_o, pad_oe_n_o, pad_pullup_o, pin_in_o, adc_pin_en_o, analog_claim_o;
  logic [4:0] comparator_en_o;
  logic [4:0][7:0] comparator_ctrl_o;
  logic [8:0] exp_q[$];
  int n_errors = 0, n_tests = 0;
  localparam logic [16:0] CLAIM [5] = '{17'h00018, 17'h00020, 17'h00080, 17'h00040, 17'h00800};

  port_pin_function_mux DUT (.mclk_i, .rst_n_i, .sfr_addr_i, .sfr_wr_i, .sfr_rd_i, .sfr_wdata_i,
    .sfr_rdata_o, .sfr_hit_o, .port_data_i, .port1_low_pin_modes_i, .pwm_b_output_i, .pwm_a_pos_output_i,
    .pwm_a_neg_output_i, .timer_ovf_i, .twm_data_out_i, .twm_clock_out_i, .twm_ack_i, .twm_done_i,
    .pad_in_i, .pad_out_o, .pad_oe_n_o, .pad_pullup_o, .pin_in_o, .adc_pin_en_o, .analog_claim_o,
    .comparator_en_o, .two_wire_master_en_o, .amplifier_en_o, .amplifier_out_pin_o, .timer_clkout_o,
    .comparator_ctrl_o, .two_wire_ctrl_o, .amplifier_ctrl_o, .amplifier_cal_o);
  pad_world PW (.pad_out_i(pad_out_o), .pad_oe_n_i(pad_oe_n_o), .pad_pullup_i(pad_pullup_o),
    .ext_i(ext_level), .pad_in_o(pad_in_i));

  always #10 mclk_i = ~mclk_i;

  // ===========================================================
  // checking
  task automatic check(input logic [16:0] seen, input logic [16:0] want);
    n_tests++;
    if (seen !== want) begin
      n_errors++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, want);
    end
  endtask

  task automatic tally_and_finish;
    if (n_errors == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // read answers are compared in the cycle after the strobe is taken
  always @(posedge mclk_i) took <= sfr_rd_i;
  always @(negedge mclk_i) if (took) begin
    if (exp_q.size() == 0) check(17'h1ffff, 17'h0);
    else check(17'({sfr_hit_o, sfr_rdata_o}), 17'(exp_q.pop_front()));
  end

  // ===========================================================
  // register strobes
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk_i) {sfr_wr_i, sfr_addr_i, sfr_wdata_i} = {1'b1, a, d};
    @(negedge mclk_i) sfr_wr_i = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [8:0] e);
    exp_q.push_back(e);
    @(negedge mclk_i) {sfr_rd_i, sfr_addr_i} = {1'b1, a};
    @(negedge mclk_i) sfr_rd_i = 1'b0;
  endtask

  // writes up to four address/data pairs, address 00 skipped
  task automatic wr_list(input logic [63:0] l);
    for (int t = 3; t >= 0; t--) if (l[t*16+8 +: 8] != 8'h00) wr(l[t*16+8 +: 8], l[t*16 +: 8]);
  endtask

  task automatic settle;
    repeat (3) @(negedge mclk_i);
  endtask

  // ===========================================================
  // sequence
  initial begin
    logic [7:0] r;
    logic [16:0] e;
    logic drv;
    int i, k;
    void'($urandom(11982));
    repeat (5) @(negedge mclk_i);
    rst_n_i = 1'b1;
    check(pad_oe_n_o, 17'h1ffff);
    for (i = 0; i < port_mux_pkg::NUM_REGS; i++) rd(port_mux_pkg::REG_ADDR[i], {1'b1, port_mux_pkg::REG_RESET[i]});
    twm_ack_i = 1'($urandom);
    for (i = 0; i < port_mux_pkg::NUM_REGS; i++) begin
      r = 8'($urandom);
      wr(port_mux_pkg::REG_ADDR[i], r);
      e = 17'(r & port_mux_pkg::REG_WMASK[i] | (i == port_mux_pkg::REG_TWM ? {3'h0, twm_ack_i, 4'h0} : 8'h00));
      rd(port_mux_pkg::REG_ADDR[i], {1'b1, e[7:0]});
    end
    // write then read back to back
    @(negedge mclk_i) {sfr_wr_i, sfr_addr_i, sfr_wdata_i} = {1'b1, 8'ha3, 8'h9c};
    exp_q.push_back(9'h19c);
    @(negedge mclk_i) {sfr_wr_i, sfr_rd_i} = 2'b01;
    @(negedge mclk_i) sfr_rd_i = 1'b0;
    wr(8'ha7, 8'hff);
    rd(8'ha7, 9'h000);
    @(negedge mclk_i) rst_n_i = 1'b0;
    repeat (2) @(negedge mclk_i);
    rst_n_i = 1'b1;
    rd(8'ha6, 9'h101);
    for (i = 0; i < 8; i++) begin
      wr(8'ha5, {2'h1, 2'(i >> 1), 4'h5});
      port_data_i[15] = i[0];
      ext_level[15] = 1'($urandom);
      settle;
      drv = (i >> 1 == 2) || (i < 4 && !i[0]);
      e = {12'h0, !drv, i == 1, i[0] && i < 4 && (i == 1 || ext_level[15]), drv && i[0], i >= 6};
      check({12'h0, pad_oe_n_o[15], pad_pullup_o[15], pin_in_o[15], drv & pad_out_o[15], adc_pin_en_o[15]}, e);
    end
    wr_list(64'ha4c0_a503_a330_a603);
    check(adc_pin_en_o, 17'h03140);
    wr_list(64'ha4ff_a5ff_0000_0000);
    check(adc_pin_en_o, 17'h1ff40);
    port1_low_pin_modes_i = 8'h66;
    port_data_i = 17'h0;
    wr_list(64'ha495_a55a_0000_0000);
    for (k = 0; k < 8; k++) begin
      {pwm_b_output_i, pwm_a_pos_output_i, pwm_a_neg_output_i} = 3'($urandom);
      wr(8'ha6, {3'(k), 5'h0});
      settle;
      e = 17'(3'(k) & {pwm_b_output_i, pwm_a_pos_output_i, pwm_a_neg_output_i});
      check(17'({pad_out_o[12], pad_out_o[14], pad_out_o[2]}), e);
    end
    wr(8'ha6, 8'h1c);
    for (k = 1; k <= 33; k++) begin
      @(negedge mclk_i) timer_ovf_i = 3'h7;
      @(negedge mclk_i) timer_ovf_i = 3'h0;
      @(negedge mclk_i);
      e = 17'({k[0], k[0], k[5]});
      check(17'(timer_clkout_o), e);
      check(17'({pad_out_o[0], pad_out_o[14], pad_out_o[13]}), e);
    end
    wr(8'ha6, 8'h00);
    settle;
    check(17'(timer_clkout_o), 17'h0);
    for (i = 0; i < 5; i++) begin
      wr(8'hc1 + 8'(i), 8'h80);
      settle;
      check(analog_claim_o, CLAIM[i]);
      check(17'(comparator_en_o) | (pad_oe_n_o & CLAIM[i]), 17'(1 << i) | CLAIM[i]);
      wr(8'hc1 + 8'(i), 8'h00);
    end
    for (i = 0; i < 16; i++) begin
      wr(8'hef, {1'b0, i[3], 6'h0});
      wr(8'hee, {2'h2, i[0], 2'(i >> 1), 3'h0});
      settle;
      e = i[3] ? 17'(i[2:1] == 3 ? 3 : 0) : 17'(i[2:1] == 0 ? 1 : (i[2:1] == 3 ? 3 : 2));
      check(analog_claim_o, e | {10'h0, i[0], 6'h0});
      check(17'({amplifier_out_pin_o, amplifier_en_o}), 17'({i[0], 1'b1}));
    end
    wr(8'hee, 8'h38);
    check(analog_claim_o | 17'(amplifier_out_pin_o), 17'h0);
    port1_low_pin_modes_i = 8'h55;
    port_data_i = 17'h1ffff;
    @(negedge mclk_i);
    check(17'({pad_oe_n_o[0], pad_out_o[0]}), 17'h1);
    wr(8'he1, 8'h84);
    for (k = 0; k < 4; k++) begin
      {twm_data_out_i, twm_clock_out_i} = 2'(k);
      settle;
      check(17'({pad_oe_n_o[9], pad_oe_n_o[10], two_wire_master_en_o}), 17'({k[1], k[0], 1'b1}));
    end
    // completion flag set in the same cycle as a clearing write
    @(negedge mclk_i) {twm_done_i, sfr_wr_i, sfr_addr_i, sfr_wdata_i} = {2'b11, 8'he1, 8'h80};
    @(negedge mclk_i) {twm_done_i, sfr_wr_i} = 2'b00;
    rd(8'he1, {1'b1, 8'ha0 | {3'h0, twm_ack_i, 4'h0}});
    settle;
    tally_and_finish;
  end
endmodule

`default_nettype wire
